/* hw/tmr16_params.svh */
// Offsets, field positions and reset values of the 16-bit capture/compare timer.
// Assumes an 8-bit internal bus with byte addresses in the low page.
`ifndef TMR16_PARAMS_SVH
`define TMR16_PARAMS_SVH

// ==================================================
// Register offsets
`define TMR16_A_CAP2_HI   8'h0F
`define TMR16_A_CAP2_LO   8'h10
`define TMR16_A_CTRL      8'h11
`define TMR16_A_STAT      8'h12
`define TMR16_A_CAP1_HI   8'h13
`define TMR16_A_CAP1_LO   8'h14
`define TMR16_A_CMP1_HI   8'h15
`define TMR16_A_CMP1_LO   8'h16
`define TMR16_A_CMP2_HI   8'h17
`define TMR16_A_CMP2_LO   8'h18
`define TMR16_A_CNT_HI    8'h19
`define TMR16_A_CNT_LO    8'h1A
`define TMR16_A_ALT_HI    8'h1B
`define TMR16_A_ALT_LO    8'h1C
`define TMR16_A_PINCFG    8'h1D

// ==================================================
// Field positions and values
`define TMR16_EN_HI       7
`define TMR16_EN_LO       3
`define TMR16_EDGE_TWO    1
`define TMR16_EDGE_ONE    0
`define TMR16_ROUTE_SIX   6
`define TMR16_ROUTE_SEVEN 7
`define TMR16_CNT_RESET   16'h0000
`define TMR16_CNT_MAX     16'hFFFF
`define TMR16_CNT_STEP    16'h0001
`define TMR16_PAD_ZERO    3'h0
`define TMR16_BYTE_ZERO   8'h00
`define TMR16_PINCFG_RST  2'h0

`endif

/* hw/tmr16_pkg.sv */
// Types shared by the capture/compare timer and its surroundings.
// Assumes the CPU presents one access per bus clock at most.
package tmr16_pkg;

  // ==================================================
  // Bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       rd;
    logic       wr;
  } tmr16_bus_t;

  // ==================================================
  // Timer states inside one counter step
  typedef enum logic [1:0] {T00, T01, T10, T11} tmr16_state_t;

endpackage

/* hw/tmr16_timer.sv */
// 16-bit free-running timer with two input captures, two compare registers and overflow.
// Assumes the CPU bus runs on i_sys_clk and port pins are asynchronous.
`timescale 1ns/100ps
`include "tmr16_params.svh"

module tmr16_timer (
  input  wire logic            i_sys_clk,
  input  wire logic            i_sys_rst,
  input  tmr16_pkg::tmr16_bus_t i_bus,
  input  wire logic            i_halt,
  input  wire logic            i_port_c_pin_six,
  input  wire logic            i_port_c_pin_seven,
  output logic [7:0]           o_rdata,
  output logic                 o_irq
);
  import tmr16_pkg::*;

  // ==================================================
  // State
  tmr16_state_t state;
  logic [15:0]  cnt;
  logic [7:0]   timer_control;
  logic [1:0]   timer_pin_config;
  logic [15:0]  cap [2];
  logic [1:0]   cap_inhibit;
  logic [1:0]   cap_pend;
  logic [15:0]  cmp [2];
  logic [1:0]   cmp_inhibit;
  logic [1:0]   cmp_pend;
  logic [4:0]   flag;
  logic [4:0]   arm;
  logic [4:0]   set_ev;
  logic [4:0]   clr_hit;
  logic [1:0]   cap_ev;
  logic [1:0]   pin_raw;
  logic [1:0]   sync1;
  logic [1:0]   sync2;
  logic [1:0]   sync3;
  logic [7:0]   stat_byte;
  logic         wrap;

  // Index 1 is capture one, index 0 capture two; flag order follows the status byte.
  assign pin_raw   = {i_port_c_pin_six, i_port_c_pin_seven};
  assign stat_byte = {flag, `TMR16_PAD_ZERO};
  assign wrap      = !i_halt && state == T11 && cnt == `TMR16_CNT_MAX;

  // ==================================================
  // Prescaler and counter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= T00;
    end else if (!i_halt) begin
      case (state)
        T00:     state <= T01;
        T01:     state <= T10;
        T10:     state <= T11;
        T11:     state <= T00;
        default: state <= T00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt <= `TMR16_CNT_RESET;
    end else if (!i_halt && state == T11) begin
      cnt <= cnt + `TMR16_CNT_STEP;
    end
  end

  // ==================================================
  // Control and pin configuration
  // Edge bits and the unused bit survive reset; only the enables are cleared.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      timer_control[`TMR16_EN_HI:`TMR16_EN_LO] <= '0;
    end else if (i_bus.wr && i_bus.addr == `TMR16_A_CTRL) begin
      timer_control <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      timer_pin_config <= `TMR16_PINCFG_RST;
    end else if (i_bus.wr && i_bus.addr == `TMR16_A_PINCFG) begin
      timer_pin_config <= {i_bus.wdata[`TMR16_ROUTE_SEVEN], i_bus.wdata[`TMR16_ROUTE_SIX]};
    end
  end

  // ==================================================
  // Capture channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cap
      logic routed;
      logic edge_rise;
      assign routed = ch ? timer_pin_config[0] : timer_pin_config[1];
      assign edge_rise = ch ? timer_control[`TMR16_EDGE_ONE] : timer_control[`TMR16_EDGE_TWO];

      // The edge register tracks the pin even while it is unrouted.
      // Turning routing on therefore shows no stale level as a false edge, unless it is done while halted and the pin moved during the halt.
      always_ff @(posedge i_sys_clk) begin
        sync1[ch] <= pin_raw[ch];
        sync2[ch] <= sync1[ch];
        if (!i_halt) begin
          sync3[ch] <= sync2[ch];
        end
      end

      assign cap_ev[ch] = routed && !i_halt && (sync2[ch] != sync3[ch]) &&
                          (sync2[ch] == edge_rise);

      always_ff @(posedge i_sys_clk) begin
        if (cap_ev[ch] && !cap_inhibit[ch]) begin
          cap[ch] <= cnt + `TMR16_CNT_STEP;
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          cap_inhibit[ch] <= 1'b0;
        end else if (i_bus.rd && i_bus.addr == (ch ? `TMR16_A_CAP1_HI : `TMR16_A_CAP2_HI)) begin
          cap_inhibit[ch] <= 1'b1;
        end else if (i_bus.rd && i_bus.addr == (ch ? `TMR16_A_CAP1_LO : `TMR16_A_CAP2_LO)) begin
          cap_inhibit[ch] <= 1'b0;
        end
      end

      // The pending bit carries an edge seen anywhere in the step to the next T11.
      // An edge sampled on the T11 edge itself belongs to the next step, so it is kept, not lost.
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          cap_pend[ch] <= 1'b0;
        end else if (!i_halt && state == T11) begin
          cap_pend[ch] <= cap_ev[ch];
        end else if (cap_ev[ch]) begin
          cap_pend[ch] <= 1'b1;
        end
      end

      // ==================================================
      // Compare channel
      always_ff @(posedge i_sys_clk) begin
        if (i_bus.wr && i_bus.addr == (ch ? `TMR16_A_CMP1_HI : `TMR16_A_CMP2_HI)) begin
          cmp[ch][15:8] <= i_bus.wdata;
        end
        if (i_bus.wr && i_bus.addr == (ch ? `TMR16_A_CMP1_LO : `TMR16_A_CMP2_LO)) begin
          cmp[ch][7:0] <= i_bus.wdata;
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          cmp_inhibit[ch] <= 1'b0;
        end else if (i_bus.wr && i_bus.addr == (ch ? `TMR16_A_CMP1_HI : `TMR16_A_CMP2_HI)) begin
          cmp_inhibit[ch] <= 1'b1;
        end else if (i_bus.wr && i_bus.addr == (ch ? `TMR16_A_CMP1_LO : `TMR16_A_CMP2_LO)) begin
          cmp_inhibit[ch] <= 1'b0;
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          cmp_pend[ch] <= 1'b0;
        end else if (!i_halt && state == T01) begin
          cmp_pend[ch] <= !cmp_inhibit[ch] && cmp[ch] == cnt;
        end else if (!i_halt && state == T11) begin
          cmp_pend[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==================================================
  // Status flags with two-step clear
  assign set_ev = {{cap_pend[1], cap_pend[0], cmp_pend[1], cmp_pend[0]} & {4{!i_halt && state == T11}},
                   wrap};

  // A read or a write of the low byte counts as the second step; the alternate pair never does.
  assign clr_hit = {(i_bus.rd || i_bus.wr) && i_bus.addr == `TMR16_A_CAP1_LO,
                    (i_bus.rd || i_bus.wr) && i_bus.addr == `TMR16_A_CAP2_LO,
                    (i_bus.rd || i_bus.wr) && i_bus.addr == `TMR16_A_CMP1_LO,
                    (i_bus.rd || i_bus.wr) && i_bus.addr == `TMR16_A_CMP2_LO,
                    (i_bus.rd || i_bus.wr) && i_bus.addr == `TMR16_A_CNT_LO};

  genvar fb;
  generate
    for (fb = 0; fb < 5; fb++) begin : g_flag
      // Flags are untouched by reset, so their level after power-up is whatever it was.
      always_ff @(posedge i_sys_clk) begin
        if (set_ev[fb]) begin
          flag[fb] <= 1'b1;
        end else if (clr_hit[fb] && arm[fb]) begin
          flag[fb] <= 1'b0;
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          arm[fb] <= 1'b0;
        end else if ((i_bus.rd || i_bus.wr) && i_bus.addr == `TMR16_A_STAT && flag[fb]) begin
          arm[fb] <= 1'b1;
        end else if (clr_hit[fb]) begin
          arm[fb] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==================================================
  // Interrupt and read data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flag & timer_control[`TMR16_EN_HI:`TMR16_EN_LO]);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= `TMR16_BYTE_ZERO;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        `TMR16_A_CAP2_HI: o_rdata <= cap[0][15:8];
        `TMR16_A_CAP2_LO: o_rdata <= cap[0][7:0];
        `TMR16_A_CTRL:    o_rdata <= timer_control;
        `TMR16_A_STAT:    o_rdata <= stat_byte;
        `TMR16_A_CAP1_HI: o_rdata <= cap[1][15:8];
        `TMR16_A_CAP1_LO: o_rdata <= cap[1][7:0];
        `TMR16_A_CMP1_HI: o_rdata <= cmp[1][15:8];
        `TMR16_A_CMP1_LO: o_rdata <= cmp[1][7:0];
        `TMR16_A_CMP2_HI: o_rdata <= cmp[0][15:8];
        `TMR16_A_CMP2_LO: o_rdata <= cmp[0][7:0];
        `TMR16_A_CNT_HI:  o_rdata <= cnt[15:8];
        `TMR16_A_CNT_LO:  o_rdata <= cnt[7:0];
        `TMR16_A_ALT_HI:  o_rdata <= cnt[15:8];
        `TMR16_A_ALT_LO:  o_rdata <= cnt[7:0];
        `TMR16_A_PINCFG:  o_rdata <= {timer_pin_config, 6'h00};
        default:          o_rdata <= `TMR16_BYTE_ZERO;
      endcase
    end
  end

  // ==================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_cnt_step: assert property (!i_halt && state == T11 |=> cnt == $past(cnt) + `TMR16_CNT_STEP)
    else $error("counter did not advance at step end");
  a_halt_hold: assert property (i_halt |=> $stable(cnt) && $stable(state) && $stable(flag))
    else $error("timer state moved while halted");
  a_cap_value: assert property (cap_ev[0] && !cap_inhibit[0] |=> cap[0] == $past(cnt) + `TMR16_CNT_STEP)
    else $error("capture two value wrong");
  a_cap_block: assert property (cap_inhibit[1] |=> $stable(cap[1]))
    else $error("capture one overwritten while blocked");
  a_cap_flag: assert property (cap_ev[0] |-> ##[1:4] (state == T11) ##1 flag[3])
    else $error("capture two flag not set by next T11");
  a_ovf_set: assert property (wrap |=> flag[0] && cnt == `TMR16_CNT_RESET)
    else $error("overflow flag missing on wrap");
  a_flag_clear: assert property ($fell(flag[0]) |-> $past(arm[0]) && $past(clr_hit[0]))
    else $error("overflow flag cleared without two steps");
  a_irq_follow: assert property (##1 o_irq == $past(|(flag & timer_control[`TMR16_EN_HI:`TMR16_EN_LO])))
    else $error("interrupt does not follow flags and enables");
  a_ctrl_reset: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    i_sys_rst |=> timer_control[`TMR16_EN_HI:`TMR16_EN_LO] == '0)
    else $error("enables not cleared by reset");
  a_cap_one_value: assert property (cap_ev[1] && !cap_inhibit[1] |=>
    cap[1] == $past(cnt) + `TMR16_CNT_STEP)
    else $error("capture one value wrong");
  a_cap_clear: assert property ($fell(flag[4]) |-> $past(arm[4]) && $past(clr_hit[4]))
    else $error("capture one flag cleared without two steps");
  a_cmp_block: assert property (cmp_inhibit[1] && !i_halt && state == T01 |=> !cmp_pend[1])
    else $error("compare one matched while suspended");

  c_capture_two: cover property (cap_ev[0] ##[1:8] flag[3]);
  c_cmp_hit:     cover property (cmp_pend[1] ##1 flag[2]);
  c_ovf_clear:   cover property (flag[0] ##[1:20] $fell(flag[0]));
  c_irq:         cover property ($rose(o_irq));

endmodule

/* verification/tb_top.sv */
// Self-checking bench for the 16-bit capture/compare timer.
// Assumes the timer header, package and pin source model are compiled first.
`timescale 1ns/100ps
`include "tmr16_params.svh"

module tb_top;
  import tmr16_pkg::*;
  logic        i_sys_clk;
  logic        i_sys_rst;
  tmr16_bus_t  bus;
  logic        halt;
  logic [1:0]  level;
  logic        pin_six;
  logic        pin_seven;
  logic [7:0]  rdata;
  logic        irq;
  int          mismatches;
  int          cmp_count;
  int          ch;
  logic [7:0]  q, h, l, h2, l2, m, a_hi, a_lo;
  logic [15:0] c, t;

  tmr16_timer i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .i_halt(halt),
    .i_port_c_pin_six(pin_six), .i_port_c_pin_seven(pin_seven), .o_rdata(rdata), .o_irq(irq));
  tmr16_pin_src i_pins (.i_sys_clk(i_sys_clk), .i_level(level), .o_pin_six(pin_six),
    .o_pin_seven(pin_seven));

  // ==================================================
  // Bus tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] r);
    @(posedge i_sys_clk);
    #10;
    bus = '{addr: a, wdata: d, rd: ~w, wr: w};
    @(posedge i_sys_clk);
    #10;
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    r = rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(a, d, 1'b1, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    acc(a, 8'h00, 1'b0, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    logic [7:0] r;
    rd(a, r);
    check(r & msk, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #10;
  endtask

  // The alternate pair is used so that reading the time never disturbs the overflow flag.
  task automatic read_cnt(output logic [15:0] v);
    logic [7:0] lo, hi;
    rd(`TMR16_A_ALT_LO, lo);
    while (lo > 8'hF0) rd(`TMR16_A_ALT_LO, lo);
    rd(`TMR16_A_ALT_HI, hi);
    v = {hi, lo};
  endtask

  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==================================================
  // Clock and watchdog
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    complete_run();
  end

  // ==================================================
  // Tests
  initial begin
    bus = '0;
    halt = 1'b0;
    level = 2'h0;
    i_sys_rst = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    cyc(10);
    i_sys_rst = 1'b0;
    rchk(`TMR16_A_CTRL, 8'h00, 8'hF8);
    wr(`TMR16_A_CTRL, 8'h03);
    rchk(`TMR16_A_CTRL, 8'h03, 8'hFB);
    wr(`TMR16_A_PINCFG, 8'hC0);
    rchk(`TMR16_A_PINCFG, 8'hC0, 8'hFF);
    rchk(8'h05, 8'h00, 8'hFF);
    for (ch = 0; ch < 2; ch++) begin
      m = 8'h80 >> ch;
      a_hi = ch ? `TMR16_A_CAP2_HI : `TMR16_A_CAP1_HI;
      a_lo = ch ? `TMR16_A_CAP2_LO : `TMR16_A_CAP1_LO;
      wr(`TMR16_A_CTRL, 8'h03);
      read_cnt(c);
      level[ch] = 1'b1;
      cyc(12);
      rchk(`TMR16_A_STAT, m, m);
      rd(a_hi, h);
      rd(a_lo, l);
      t = {h, l} - c;
      check({7'h00, t >= 16'h0001 && t <= 16'h0005}, 8'h01);
      rchk(`TMR16_A_STAT, 8'h00, m);
      level[ch] = 1'b0;
      cyc(12);
      rchk(`TMR16_A_STAT, 8'h00, m);
      rd(a_hi, h2);
      level[ch] = 1'b1;
      cyc(12);
      rchk(a_lo, l, 8'hFF);
      level[ch] = 1'b0;
      cyc(12);
      level[ch] = 1'b1;
      cyc(12);
      rd(a_hi, h2);
      rd(a_lo, l2);
      check({7'h00, {h2, l2} != {h, l}}, 8'h01);
      wr(`TMR16_A_CTRL, 8'h03 & ~(8'h01 << ch));
      rd(`TMR16_A_STAT, q);
      rd(a_lo, q);
      level[ch] = 1'b0;
      cyc(12);
      rchk(`TMR16_A_STAT, m, m);
    end
    wr(`TMR16_A_CTRL, 8'h40);
    cyc(3);
    check({7'h00, irq}, 8'h01);
    wr(`TMR16_A_CTRL, 8'h00);
    cyc(3);
    check({7'h00, irq}, 8'h00);
    wr(`TMR16_A_CTRL, 8'h40);
    rd(`TMR16_A_STAT, q);
    rd(`TMR16_A_CAP2_LO, q);
    cyc(3);
    check({7'h00, irq}, 8'h00);
    read_cnt(c);
    t = c + 16'h0014;
    wr(`TMR16_A_CMP1_HI, t[15:8]);
    wr(`TMR16_A_CMP1_LO, t[7:0]);
    cyc(100);
    rchk(`TMR16_A_STAT, 8'h20, 8'h20);
    wr(`TMR16_A_CMP1_LO, t[7:0]);
    rchk(`TMR16_A_STAT, 8'h00, 8'h20);
    read_cnt(c);
    t = c + 16'h0014;
    wr(`TMR16_A_CMP1_LO, t[7:0]);
    wr(`TMR16_A_CMP1_HI, t[15:8]);
    cyc(100);
    rchk(`TMR16_A_STAT, 8'h00, 8'h20);
    halt = 1'b1;
    rd(`TMR16_A_ALT_LO, h);
    cyc(6);
    rd(`TMR16_A_ALT_LO, l);
    check(l - h, 8'h00);
    halt = 1'b0;
    rd(`TMR16_A_ALT_LO, h);
    cyc(6);
    rd(`TMR16_A_ALT_LO, l);
    check(l - h, 8'h02);
    wr(`TMR16_A_CTRL, 8'h43);
    rd(`TMR16_A_CAP2_HI, h);
    rd(`TMR16_A_CAP2_LO, l);
    wr(`TMR16_A_CAP2_HI, ~h);
    rchk(`TMR16_A_CAP2_HI, h, 8'hFF);
    rd(`TMR16_A_CAP2_LO, q);
    i_sys_rst = 1'b1;
    cyc(2);
    i_sys_rst = 1'b0;
    rchk(`TMR16_A_CTRL, 8'h03, 8'hFB);
    rchk(`TMR16_A_PINCFG, 8'h00, 8'hFF);
    rchk(`TMR16_A_CAP2_HI, h, 8'hFF);
    rchk(`TMR16_A_CAP2_LO, l, 8'hFF);
    complete_run();
  end
endmodule

/* verification/tmr16_pin_src.sv */
// Stand-in for the external signals on the two capture port pins.
// Assumes the bench sets target levels; pins follow away from the clock edge.
`timescale 1ns/100ps

module tmr16_pin_src (
  input  wire logic       i_sys_clk,
  input  wire logic [1:0] i_level,
  output logic            o_pin_six,
  output logic            o_pin_seven
);
  // ==================================================
  // Pin drive
  // Moving 37 ns after each rising edge keeps the pins off the timer's clock edge, though always at the same phase to it.
  initial begin
    o_pin_six   = 1'b0;
    o_pin_seven = 1'b0;
    forever begin
      @(posedge i_sys_clk);
      #37;
      o_pin_six   = i_level[0];
      o_pin_seven = i_level[1];
    end
  end
endmodule
